//--- shared/piconet_map.svh
// constants for the piconet slot scheduler
`ifndef PICONET_MAP_SVH
`define PICONET_MAP_SVH
`define CLK_PERIOD_NS 20
`define SLOT_US 625
`define HALF_SLOT_CYC ((`SLOT_US * 1000 / 2) / `CLK_PERIOD_NS)
`define FULL_BASE_MHZ 12'h962
`define FULL_CHANNELS 7'h4f
`define REDUCED_CHANNELS 7'h17
`define MAX_SLOTS 3'h5
`define SCO_LIMIT 2'h3
`define SCO_LIMIT_MULTI 2'h2
`define SCO_ENTRIES 3
`define BROADCAST_ADDR 3'h0
`endif

//--- shared/piconet_pkg.sv
// types for the piconet slot scheduler
package piconet_pkg;
  typedef enum logic [1:0] {TX_SCO, TX_ACL, TX_POLL} txKind_t;
  typedef enum logic {SCHED_FREE, SCHED_BUSY} schedState_t;
  typedef struct packed {
    txKind_t kind;
    logic [2:0] len;
    logic [2:0] dest;
    logic retx;
  } txInfo_t;
  typedef struct packed {
    logic [7:0] syncIntervalSlots;
    logic [7:0] syncOffsetSlots;
    logic initFlag;
  } scoCfg_t;
endpackage : piconet_pkg

//--- rtl/piconet_slot_scheduler.sv
// slot timing and channel access scheduler for a hopping tdd link
`timescale 1ns/1ps
`include "piconet_map.svh"
// Notes on behaviour
// - at most seven active slaves, parked never served
// - carrier is base plus channel index k
// - timeline cut into 625 us slots
// - slot number from master clock, wraps at 2^27
// - master starts even slots, slave odd slots
// - every packet starts on a slot boundary
// - a packet spans at most five slots
// - multi-slot packet keeps first slot's hop clock
// - slot after packet uses current clock again
// - at most three sync links, two multi-master
// - sync packets are never retransmitted
// - master sends in every reserved sync slot; here it skips one that its own multi-slot packet covers
// - sync slave answers unless another slave addressed; here it also skips one its own multi-slot packet covers
// - init method from clock msb, slave uses flag
// - reserved slot where clock mod interval equals offset
// - slave sync slot directly follows master slot
// - next reserved slot is current plus interval
// - async traffic only in unreserved slots; here only a packet's first slot is checked
// - one async link per master and slave
// - slave answers async only when addressed
// - unaddressed async packets taken as broadcast
// - nothing queued and no poll means silence
module piconet_slot_scheduler #(
  parameter int HALF_SLOT_CYC = `HALF_SLOT_CYC
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic isMaster,
  input wire logic multiMaster,
  input wire logic [2:0] myAddr,
  input wire logic [6:0] activeMask,
  input wire logic clkLoad,
  input wire logic [27:0] clkLoadValue,
  input wire logic [6:0] hopIndex,
  input wire logic reducedBand,
  input wire logic [11:0] reducedBase,
  input wire logic aclReq,
  input wire logic [2:0] aclLen,
  input wire logic [2:0] aclDest,
  input wire logic aclRetx,
  input wire logic pollReq,
  input wire logic rxStrobe,
  input wire logic rxDecodeOk,
  input wire logic [2:0] rxAddr,
  input wire logic scoSetup,
  input wire logic scoRelease,
  input wire logic [1:0] scoIndex,
  input wire piconet_pkg::scoCfg_t scoCfg,
  output logic [27:0] masterClock,
  output logic [27:0] hopClock,
  output logic slotStart,
  output logic [11:0] carrierMhz,
  output logic carrierValid,
  output logic txStart,
  output piconet_pkg::txInfo_t txInfo,
  output logic txActive,
  output logic aclTaken,
  output logic rxAccept,
  output logic rxBroadcast,
  output logic [2:0] scoActive,
  output logic scoRefused
);

  // ****************************************
  // slot timing
  // ****************************************
  logic [15:0] halfCnt;
  piconet_pkg::schedState_t state;
  logic [2:0] remain;
  logic scoPrev;
  logic addressedMe;
  logic otherAddressed;

  // two half-slot ticks make one 625 us slot
  wire halfTick = (halfCnt == 16'(HALF_SLOT_CYC - 1));
  // 28-bit clock wrap gives the 2^27 slot wrap
  wire [27:0] nextClk = masterClock + 28'h1;
  wire slotEdge = halfTick && !nextClk[0];
  wire [26:0] newSlot = nextClk[27:1];
  wire evenSlot = !newSlot[0];

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      halfCnt <= 16'h0;
      masterClock <= 28'h0;
    end else if (clkLoad) begin
      halfCnt <= 16'h0;
      masterClock <= clkLoadValue;
    end else begin
      halfCnt <= halfTick ? 16'h0 : halfCnt + 16'h1;
      masterClock <= halfTick ? nextClk : masterClock;
    end
  end

  // ****************************************
  // synchronous reservations
  // ****************************************
  logic [2:0] scoWait;
  logic [2:0] scoMeth;
  logic [7:0] scoIntv [3];
  logic [7:0] scoOfs [3];
  logic [26:0] scoNext [3];
  wire [2:0] initHit;
  wire [2:0] resHit;
  wire [1:0] scoCount = {1'b0, scoActive[0]} + {1'b0, scoActive[1]} +
    {1'b0, scoActive[2]};
  // a slave in several piconets holds fewer links
  wire [1:0] scoLimit = (!isMaster && multiMaster) ?
    `SCO_LIMIT_MULTI : `SCO_LIMIT;
  wire setupOk = scoSetup && scoIndex != 2'h3 &&
    !scoActive[scoIndex] && scoCount < scoLimit &&
    scoCfg.syncIntervalSlots != 8'h0;
  // master picks method by clock msb, slave obeys the flag
  wire setupMeth = isMaster ? masterClock[27] : scoCfg.initFlag;

  generate
    for (genvar i = 0; i < `SCO_ENTRIES; i++) begin : g_sco
      // method two inverts the clock msb to dodge wrap trouble
      wire [26:0] key = scoMeth[i] ?
        {~newSlot[26], newSlot[25:0]} : newSlot;
      wire [26:0] rem = key % {19'h0, scoIntv[i]};
      assign initHit[i] = scoActive[i] && scoWait[i] &&
        rem == {19'h0, scoOfs[i]};
      assign resHit[i] = scoActive[i] && !scoWait[i] &&
        newSlot == scoNext[i];
      wire mine = setupOk && scoIndex == 2'(i);
      wire gone = scoRelease && scoIndex == 2'(i);
      always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          scoActive[i] <= 1'b0;
          scoWait[i] <= 1'b0;
          scoMeth[i] <= 1'b0;
          scoIntv[i] <= 8'h0;
          scoOfs[i] <= 8'h0;
          scoNext[i] <= 27'h0;
        end else if (gone) begin
          scoActive[i] <= 1'b0;
        end else if (mine) begin
          scoActive[i] <= 1'b1;
          scoWait[i] <= 1'b1;
          scoMeth[i] <= setupMeth;
          scoIntv[i] <= scoCfg.syncIntervalSlots;
          scoOfs[i] <= scoCfg.syncOffsetSlots;
        end else if (slotEdge && (initHit[i] || resHit[i])) begin
          scoWait[i] <= 1'b0;
          scoNext[i] <= newSlot + {19'h0, scoIntv[i]};
        end
      end
    end
  endgenerate

  // ****************************************
  // channel access decision
  // ****************************************
  wire scoHit = |(initHit | resHit);
  wire lenOk = aclLen == 3'h1 || aclLen == 3'h3 ||
    aclLen == `MAX_SLOTS;
  // one link per address; parked slaves own no bit here
  wire destOk = aclDest == `BROADCAST_ADDR ||
    activeMask[3'(aclDest - 3'h1)];
  wire freeSlot = state == piconet_pkg::SCHED_FREE || remain <= 3'h1;
  wire mSlot = freeSlot && isMaster && evenSlot;
  wire sSlot = freeSlot && !isMaster && !evenSlot;
  wire mSco = mSlot && scoHit;
  wire mAcl = mSlot && !scoHit && aclReq && lenOk && destOk;
  wire mPoll = mSlot && !scoHit && !mAcl && pollReq && destOk;
  // a failed decode never counts as another slave
  wire sSco = sSlot && scoPrev && !otherAddressed;
  wire sAcl = sSlot && !sSco && addressedMe && aclReq && lenOk;
  wire startNow = mSco || mAcl || mPoll || sSco || sAcl;
  wire scoNow = mSco || sSco;
  wire pollNow = mPoll && !mSco;

  // packet start, length tracking and hop clock hold
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= piconet_pkg::SCHED_FREE;
      remain <= 3'h0;
      hopClock <= 28'h0;
      txStart <= 1'b0;
      txActive <= 1'b0;
      aclTaken <= 1'b0;
      slotStart <= 1'b0;
      scoPrev <= 1'b0;
      txInfo <= '{piconet_pkg::TX_ACL, 3'h0, 3'h0, 1'b0};
    end else begin
      slotStart <= slotEdge;
      txStart <= slotEdge && startNow;
      aclTaken <= slotEdge && (mAcl || sAcl);
      if (slotEdge) begin
        scoPrev <= scoHit && evenSlot;
      end
      if (clkLoad) begin
        hopClock <= clkLoadValue;
      end else if (slotEdge && freeSlot) begin
        hopClock <= nextClk;
      end
      if (slotEdge && !freeSlot) begin
        remain <= remain - 3'h1; // hop clock held
      end else if (slotEdge && startNow) begin
        state <= piconet_pkg::SCHED_BUSY;
        txActive <= 1'b1;
        remain <= (scoNow || pollNow) ? 3'h1 : aclLen;
        txInfo.kind <= scoNow ? piconet_pkg::TX_SCO :
          (pollNow ? piconet_pkg::TX_POLL : piconet_pkg::TX_ACL);
        txInfo.len <= (scoNow || pollNow) ? 3'h1 : aclLen;
        txInfo.dest <= isMaster ? aclDest : myAddr;
        txInfo.retx <= !scoNow && aclRetx;
      end else if (slotEdge) begin
        state <= piconet_pkg::SCHED_FREE;
        txActive <= 1'b0;
        remain <= 3'h0;
      end
    end
  end

  // ****************************************
  // receive side addressing
  // ****************************************
  wire rxMine = rxDecodeOk && rxAddr == myAddr;
  wire rxBcast = rxDecodeOk && rxAddr == `BROADCAST_ADDR;
  // set wins over the clear at the next master slot start
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      addressedMe <= 1'b0;
      otherAddressed <= 1'b0;
      rxAccept <= 1'b0;
      rxBroadcast <= 1'b0;
      scoRefused <= 1'b0;
    end else begin
      if (rxStrobe) begin
        addressedMe <= rxMine;
        otherAddressed <= rxDecodeOk && !rxMine && !rxBcast;
      end else if (slotEdge && evenSlot) begin
        addressedMe <= 1'b0;
        otherAddressed <= 1'b0;
      end
      rxAccept <= rxStrobe && (rxMine || rxBcast);
      rxBroadcast <= rxStrobe && rxBcast;
      scoRefused <= scoSetup && !setupOk;
    end
  end

  // ****************************************
  // hop carrier
  // ****************************************
  wire [11:0] base = reducedBand ? reducedBase : `FULL_BASE_MHZ;
  wire [6:0] chanCount = reducedBand ? `REDUCED_CHANNELS : `FULL_CHANNELS;
  // the index comes from a hop generator fed by hopClock
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      carrierMhz <= 12'h0;
      carrierValid <= 1'b0;
    end else begin
      carrierMhz <= base + {5'h0, hopIndex};
      carrierValid <= hopIndex < chanCount;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_slot_begin;
    slotStart ##1 !slotStart [*8];
  endsequence

  a_start_on_edge: assert property (txStart |-> slotStart)
    else $error("packet started off a slot boundary");
  a_master_even: assert property (
    txStart && $past(isMaster) |-> !masterClock[1])
    else $error("master started in an odd slot");
  a_slave_odd: assert property (
    txStart && !$past(isMaster) |-> masterClock[1])
    else $error("slave started in an even slot");
  a_len_limit: assert property (
    txStart |-> txInfo.len <= `MAX_SLOTS && txInfo.len[0])
    else $error("packet length out of range");
  a_hop_hold: assert property (
    slotStart && txActive && !txStart |-> $stable(hopClock))
    else $error("hop clock moved inside a packet");
  a_hop_resume: assert property (
    slotStart && !txActive |-> hopClock == masterClock)
    else $error("hop clock not current after packet");
  a_sco_noretx: assert property (
    txStart && txInfo.kind == piconet_pkg::TX_SCO |-> !txInfo.retx)
    else $error("sync packet marked for retransmit");
  a_sco_limit: assert property ($countones(scoActive) <= 3)
    else $error("too many sync links");
  a_slave_addressed: assert property (
    txStart && txInfo.kind == piconet_pkg::TX_ACL && !$past(isMaster)
    |-> $past(addressedMe))
    else $error("slave sent async without being addressed");
  a_broadcast_rx: assert property (
    rxStrobe && rxDecodeOk && rxAddr == 3'h0 |=> rxAccept)
    else $error("broadcast packet not accepted");
  a_slot_spacing: assert property (slotStart |-> s_slot_begin)
    else $error("slot starts too close together");

endmodule : piconet_slot_scheduler

//--- testbench/peer_controller.sv
// peer link controller model that sends packet headers to the scheduler
`timescale 1ns/1ps
module peer_controller (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic go,
  input wire logic [2:0] goAddr,
  input wire logic goOk,
  output logic rxStrobe,
  output logic rxDecodeOk,
  output logic [2:0] rxAddr
);
  logic [2:0] lastAddr;
  logic lastOk;
  // ************************************************************
  // header delivery
  // ************************************************************
  // one header per go, sent inside the master slot the bench picks
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rxStrobe <= 1'b0;
      lastAddr <= 3'h0;
      lastOk <= 1'b0;
    end else begin
      rxStrobe <= go;
      if (go) begin
        lastAddr <= goAddr;
        lastOk <= goOk;
      end
    end
  end
  // released lines show the inverse of the last header, so rxDecodeOk reads high while idle after a failed or reset header
  assign rxAddr = rxStrobe ? lastAddr : ~lastAddr;
  assign rxDecodeOk = rxStrobe ? lastOk : ~lastOk;
endmodule : peer_controller

//--- testbench/piconet_slot_scheduler_bench.sv
// self-checking bench for the piconet slot scheduler
`timescale 1ns/1ps
module piconet_slot_scheduler_bench;
  logic clk_sys = 1'b0, reset_n = 1'b0, isMaster = 1'b1;
  logic multiMaster = 1'b0, clkLoad = 1'b0, reducedBand = 1'b0;
  logic aclReq = 1'b0, aclRetx = 1'b0, pollReq = 1'b0, go = 1'b0;
  logic goOk = 1'b0, scoSetup = 1'b0, scoRelease = 1'b0;
  logic [2:0] myAddr = 3'h3, aclLen = 3'h3, aclDest = 3'h2, goAddr = 3'h0;
  logic [6:0] activeMask = 7'h3f, hopIndex = 7'h00;
  logic [27:0] clkLoadValue = 28'h0;
  logic [11:0] reducedBase = 12'h9a9;
  logic [1:0] scoIndex = 2'h0;
  piconet_pkg::scoCfg_t scoCfg = '0;
  logic rxStrobe, rxDecodeOk, slotStart, carrierValid, txStart, txActive;
  logic aclTaken, rxAccept, rxBroadcast, scoRefused;
  logic [2:0] rxAddr, scoActive;
  logic [27:0] masterClock, hopClock, h;
  logic [11:0] carrierMhz;
  piconet_pkg::txInfo_t txInfo;
  int err_total = 0, comparisons = 0;
  always #10 clk_sys = ~clk_sys;
  peer_controller peer_controller_inst (.clk_sys(clk_sys),
    .reset_n(reset_n), .go(go), .goAddr(goAddr), .goOk(goOk),
    .rxStrobe(rxStrobe), .rxDecodeOk(rxDecodeOk), .rxAddr(rxAddr));
  // short slots keep the run brief: 16 cycles a slot
  piconet_slot_scheduler #(.HALF_SLOT_CYC(8)) piconet_slot_scheduler_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .isMaster(isMaster),
    .multiMaster(multiMaster), .myAddr(myAddr), .activeMask(activeMask),
    .clkLoad(clkLoad), .clkLoadValue(clkLoadValue), .hopIndex(hopIndex),
    .reducedBand(reducedBand), .reducedBase(reducedBase), .aclReq(aclReq),
    .aclLen(aclLen), .aclDest(aclDest), .aclRetx(aclRetx),
    .pollReq(pollReq), .rxStrobe(rxStrobe), .rxDecodeOk(rxDecodeOk),
    .rxAddr(rxAddr), .scoSetup(scoSetup), .scoRelease(scoRelease),
    .scoIndex(scoIndex), .scoCfg(scoCfg), .masterClock(masterClock),
    .hopClock(hopClock), .slotStart(slotStart), .carrierMhz(carrierMhz),
    .carrierValid(carrierValid), .txStart(txStart), .txInfo(txInfo),
    .txActive(txActive), .aclTaken(aclTaken), .rxAccept(rxAccept),
    .rxBroadcast(rxBroadcast), .scoActive(scoActive),
    .scoRefused(scoRefused));
  // ************************************************************
  // shared tasks
  // ************************************************************
  // values are read at the edge, so they are those of the cycle before
  task chk(input string n, input logic [27:0] e, input logic [27:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wrap_up;
    $display("comparisons %0d err_total %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : wrap_up
  task cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  // par 1 waits for odd slot start, 0 for even, 2 for any tx start
  task wait_for(input logic [1:0] par);
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk_sys);
      if (par == 2'h2 && txStart === 1'b1) return;
      if (par != 2'h2 && slotStart === 1'b1 && masterClock[1] === par[0])
        return;
    end
    err_total++;
    $display("mismatch wait expected event seen timeout");
    wrap_up();
  endtask : wait_for
  // ************************************************************
  // scenarios
  // ************************************************************
  task t_multislot;
    wait_for(2'h1);
    aclReq <= 1'b1;
    wait_for(2'h0);
    chk("txStart", 1, txStart);
    chk("aclTaken", 1, aclTaken);
    chk("kind", piconet_pkg::TX_ACL, txInfo.kind);
    chk("len", 3, txInfo.len);
    chk("dest", 2, txInfo.dest);
    chk("hopClock", masterClock, hopClock);
    h = hopClock;
    aclReq <= 1'b0;
    repeat (2) begin
      wait_for(2'h1 - masterClock[1]);
      chk("hold hop", h, hopClock);
    end
    wait_for(2'h1);
    chk("new hop", masterClock, hopClock);
    chk("txActive", 0, txActive);
    $display("test multislot done");
  endtask : t_multislot
  task t_silent(input logic [2:0] dest, input logic req);
    wait_for(2'h1);
    aclLen <= 3'h1;
    aclDest <= dest;
    aclReq <= req;
    wait_for(2'h0);
    chk("silent txStart", 0, txStart);
    aclReq <= 1'b0;
    $display("test silent done");
  endtask : t_silent
  task t_slave(input logic [2:0] a, input logic ok, input logic expTx);
    isMaster <= 1'b0;
    wait_for(2'h0);
    go <= 1'b1;
    goAddr <= a;
    goOk <= ok;
    aclReq <= 1'b1;
    cyc(1);
    go <= 1'b0;
    cyc(2);
    chk("rxAccept", ok && (a == 3'h3 || a == 3'h0), rxAccept);
    chk("rxBroadcast", ok && a == 3'h0, rxBroadcast);
    wait_for(2'h1);
    chk("slave txStart", expTx, txStart);
    aclReq <= 1'b0;
    $display("test slave done");
  endtask : t_slave
  task t_sync;
    isMaster <= 1'b1;
    aclRetx <= 1'b1;
    scoIndex <= 2'h3;
    scoSetup <= 1'b1;
    cyc(1);
    scoSetup <= 1'b0;
    cyc(1);
    chk("scoRefused", 1, scoRefused);
    scoIndex <= 2'h0;
    scoCfg <= '{syncIntervalSlots: 8'h02, syncOffsetSlots: 8'h00,
      initFlag: 1'b0};
    scoSetup <= 1'b1;
    cyc(1);
    scoSetup <= 1'b0;
    cyc(1);
    chk("scoActive", 3'h1, scoActive);
    wait_for(2'h2);
    chk("sco kind", piconet_pkg::TX_SCO, txInfo.kind);
    chk("sco retx", 0, txInfo.retx);
    h = masterClock;
    wait_for(2'h2);
    chk("sco spacing", h + 28'h4, masterClock);
    scoRelease <= 1'b1;
    cyc(1);
    scoRelease <= 1'b0;
    cyc(1);
    chk("released", 3'h0, scoActive);
    aclRetx <= 1'b0;
    $display("test sync done");
  endtask : t_sync
  task t_carrier(input logic [6:0] k, input logic r, input logic [11:0] m,
    input logic v);
    hopIndex <= k;
    reducedBand <= r;
    cyc(2);
    chk("carrierValid", v, carrierValid);
    if (v) chk("carrierMhz", m, carrierMhz);
    $display("test carrier done");
  endtask : t_carrier
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    cyc(10);
    reset_n <= 1'b1;
    t_multislot();
    t_silent(3'h7, 1'b1);
    t_silent(3'h2, 1'b0);
    t_slave(3'h3, 1'b1, 1'b1);
    t_slave(3'h3, 1'b0, 1'b0);
    t_slave(3'h5, 1'b1, 1'b0);
    t_slave(3'h0, 1'b1, 1'b0);
    t_sync();
    t_carrier(7'h05, 1'b0, 12'h967, 1'b1);
    t_carrier(7'h4e, 1'b0, 12'h9b0, 1'b1);
    t_carrier(7'h4f, 1'b0, 12'h000, 1'b0);
    t_carrier(7'h17, 1'b1, 12'h000, 1'b0);
    t_carrier(7'h16, 1'b1, 12'h9bf, 1'b1);
    wrap_up();
  end
endmodule : piconet_slot_scheduler_bench
